// *** ccr_counter.v ***
// One 16-bit charge counter with pulse prescaler, hold-off and low byte snapshot
`timescale 1ns/1ns
`include "ccr_map.vh"
module ccr_counter (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // Pulses and prescaler
   input  wire        i_pulse,
   input  wire [1:0]  i_prescl,
   // Bus side
   input  wire        i_hold,
   input  wire        i_snap,
   // Values
   output wire [15:0] o_count,
   output wire [7:0]  o_low_shadow
);

   reg  [15:0] count_q;
   reg  [15:0] count_d;
   reg  [7:0]  pre_q;
   reg  [7:0]  pre_d;
   reg  [7:0]  shadow_q;
   wire [7:0]  group_last;

   // Group size is 2^(2*prescaler): 1, 4, 16 or 64 pulses
   assign group_last = (8'h01 << {i_prescl, 1'b0}) - 8'h01;

   always @* begin
      count_d = count_q;
      pre_d   = pre_q;
      if (i_pulse && !i_hold) begin
         if (pre_q >= group_last) begin
            pre_d   = 8'h00;
            count_d = count_q + 16'h0001;
         end else begin
            pre_d = pre_q + 8'h01;
         end
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         count_q  <= `CCR_RST_COUNT;
         pre_q    <= 8'h00;
         shadow_q <= `CCR_RST_BYTE;
      end else begin
         count_q <= count_d;
         pre_q   <= pre_d;
         if (i_snap) begin
            shadow_q <= count_q[7:0];
         end
      end
   end

   assign o_count      = count_q;
   assign o_low_shadow = shadow_q;

endmodule

// *** ccr_map.vh ***
// Register map, field positions, reset values and timing counts of the charge counter readout
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define CCR_IDX_FIRST_HIGH   8'h13
`define CCR_IDX_FIRST_LOW    8'h14
`define CCR_IDX_ACTIVE_HIGH  8'h15
`define CCR_IDX_ACTIVE_LOW   8'h16
`define CCR_IDX_SLEEP_HIGH   8'h17
`define CCR_IDX_SLEEP_LOW    8'h18
`define CCR_IDX_CONTROL      8'h20

// ****************************************
// Fields and reset values
// ****************************************
`define CCR_BYTE_MSB         7
`define CCR_BYTE_LSB         0
`define CCR_PRESCL_MSB       1
`define CCR_PRESCL_LSB       0
`define CCR_RST_BYTE         8'h00
`define CCR_RST_COUNT        16'h0000
`define CCR_RST_PRESCL       2'h0
`define CCR_UNMAPPED_DATA    32'h00000000

// ****************************************
// Timing: read data returned one cycle after the request is taken
// ****************************************
`define CCR_READ_LATENCY     1

`endif

// *** ccr_props.sv ***
// Bus timing and readout checks for the charge counter readout
`timescale 1ns/1ns
module ccr_props (
   // Clock and reset
   input logic        I_CLOCK,
   input logic        I_RST,
   // Avalon-MM slave
   input logic [9:0]  i_address,
   input logic        i_read,
   input logic        i_write,
   input logic [31:0] o_readdata,
   input logic        o_waitrequest
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   wire tk  = i_read && o_waitrequest;
   wire [7:0] idx = i_address[9:2];
   wire bad = (i_address[1:0] != 2'h0) || (idx < 8'h13)
            || (idx > 8'h18 && idx != 8'h20);
   a_wait_once: assert property (o_waitrequest |=> !o_waitrequest)
      else $error("waitrequest high for more than one cycle");
   a_wait_cause: assert property (o_waitrequest |-> i_read || i_write)
      else $error("waitrequest without a request");
   a_wait_first: assert property ($rose(i_read) || $rose(i_write) |-> o_waitrequest)
      else $error("request answered without a wait cycle");
   a_no_stall: assert property (i_read || i_write |-> ##[0:1] !o_waitrequest)
      else $error("request not answered within two cycles");
   a_data_stand: assert property (!tk |=> $stable(o_readdata))
      else $error("readdata changed without a new read");
   a_upper_zero: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
      else $error("readdata upper bits not zero");
   a_unmapped_zero: assert property (tk && bad |=> o_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_bits: assert property (tk && i_address == 10'h080 |=> o_readdata[31:2] == 30'h0)
      else $error("control read has stray bits");
   c_high_rd: cover property (tk && i_address == 10'h054);
   c_low_rd: cover property (tk && i_address == 10'h058);
   c_wr: cover property (i_write && !o_waitrequest);
endmodule
bind ccr_top ccr_props u_props (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest));

// *** ccr_top.v ***
// Charge counter readout register bank on an Avalon-MM slave
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
`include "ccr_map.vh"
module ccr_top (
   // Clock and reset
   input  wire        I_CLOCK,
   input  wire        I_RST,
   // Avalon-MM slave
   input  wire [9:0]  i_address,
   input  wire        i_read,
   input  wire        i_write,
   input  wire [31:0] i_writedata,
   input  wire [3:0]  i_byteenable,
   output reg  [31:0] o_readdata,
   output wire        o_waitrequest,
   // Converter pulse and sleep mode inputs
   input  wire        i_first_pulse,
   input  wire        i_second_pulse,
   input  wire        i_sleep_mode
);

   // ****************************************
   // Decode
   // ****************************************
   function [2:0] ctr_sel;
      input [7:0] idx;
      begin
         case (idx)
            `CCR_IDX_FIRST_HIGH,  `CCR_IDX_FIRST_LOW:  ctr_sel = 3'b001;
            `CCR_IDX_ACTIVE_HIGH, `CCR_IDX_ACTIVE_LOW: ctr_sel = 3'b010;
            `CCR_IDX_SLEEP_HIGH,  `CCR_IDX_SLEEP_LOW:  ctr_sel = 3'b100;
            default:                                   ctr_sel = 3'b000;
         endcase
      end
   endfunction

   function is_high;
      input [7:0] idx;
      begin
         is_high = (idx == `CCR_IDX_FIRST_HIGH) || (idx == `CCR_IDX_ACTIVE_HIGH)
                   || (idx == `CCR_IDX_SLEEP_HIGH);
      end
   endfunction

   wire [7:0]  idx;
   wire        word_ok;
   wire [2:0]  sel;
   wire        access;
   reg         ack_q;
   reg  [1:0]  prescl_q;
   wire [15:0] count   [0:2];
   wire [7:0]  shadow  [0:2];
   wire [2:0]  pulse;

   assign idx     = i_address[9:2];
   assign word_ok = (i_address[1:0] == 2'b00);
   assign sel     = word_ok ? ctr_sel(idx) : 3'b000;
   assign access  = i_read || i_write;

   // One wait cycle, then the answer; request is held by the master meanwhile
   assign o_waitrequest = access && !ack_q;

   // Active mode pulses go to one counter, sleep mode pulses to the other
   assign pulse[0] = i_first_pulse;
   assign pulse[1] = i_second_pulse && !i_sleep_mode;
   assign pulse[2] = i_second_pulse && i_sleep_mode;

   // ****************************************
   // Counters
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_ctr
         ccr_counter u_ctr (
            .i_clk        (I_CLOCK),
            .i_rst        (I_RST),
            .i_pulse      (pulse[g]),
            .i_prescl     (prescl_q),
            .i_hold       (i_read && sel[g]),
            .i_snap       (i_read && !ack_q && sel[g] && is_high(idx)),
            .o_count      (count[g]),
            .o_low_shadow (shadow[g])
         );
      end
   endgenerate

   // ****************************************
   // Bus answer and control register
   // ****************************************
   always @(posedge I_CLOCK) begin
      if (I_RST) begin
         ack_q      <= 1'b0;
         prescl_q   <= `CCR_RST_PRESCL;
         o_readdata <= `CCR_UNMAPPED_DATA;
      end else begin
         ack_q <= access && !ack_q;
         if (i_write && !ack_q && word_ok && idx == `CCR_IDX_CONTROL && i_byteenable[0]) begin
            prescl_q <= i_writedata[`CCR_PRESCL_MSB:`CCR_PRESCL_LSB];
         end
         if (i_read && !ack_q) begin
            o_readdata <= `CCR_UNMAPPED_DATA;
            if (word_ok) begin
               case (idx)
                  `CCR_IDX_FIRST_HIGH:  o_readdata[7:0] <= count[0][15:8];
                  `CCR_IDX_FIRST_LOW:   o_readdata[7:0] <= shadow[0];
                  `CCR_IDX_ACTIVE_HIGH: o_readdata[7:0] <= count[1][15:8];
                  `CCR_IDX_ACTIVE_LOW:  o_readdata[7:0] <= shadow[1];
                  `CCR_IDX_SLEEP_HIGH:  o_readdata[7:0] <= count[2][15:8];
                  `CCR_IDX_SLEEP_LOW:   o_readdata[7:0] <= shadow[2];
                  `CCR_IDX_CONTROL:     o_readdata[1:0] <= prescl_q;
                  default:              o_readdata <= `CCR_UNMAPPED_DATA;
               endcase
            end
         end
      end
   end

endmodule

// *** charge_counter_readout_tb.sv ***
// Self-checking testbench for the charge counter readout
`timescale 1ns/1ns
module charge_counter_readout_tb;
   logic        I_CLOCK = 0, I_RST = 1, i_read = 0, i_write = 0, o_waitrequest;
   logic        i_first_pulse = 0, i_second_pulse = 0, i_sleep_mode = 0;
   logic [9:0]  i_address = 10'h000;
   logic [31:0] i_writedata = 32'h0, o_readdata;
   int          bad_count = 0, cmp_count = 0;
   // Reset reads: six counter bytes, control, unmapped, misaligned; all expect zero
   logic [9:0]  ra[9] = '{10'h04C, 10'h050, 10'h054, 10'h058, 10'h05C, 10'h060,
                           10'h080, 10'h064, 10'h055};
   ccr_top dut (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_first_pulse(i_first_pulse),
      .i_second_pulse(i_second_pulse), .i_sleep_mode(i_sleep_mode));
   always #4 I_CLOCK = ~I_CLOCK;
   task results;
      if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input [9:0] a, input [31:0] s, input [31:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected reg %h exp %h got %h", a, e, s);
      end
   endtask
   // One bus cycle; p pulses the second output while the request is up
   task bus(input [9:0] a, input w, input [31:0] d, input p, input [31:0] e);
      @(posedge I_CLOCK);
      i_address <= a; i_read <= !w; i_write <= w; i_writedata <= d; i_second_pulse <= p;
      do @(posedge I_CLOCK); while (o_waitrequest !== 1'b0);
      if (!w) chk(a, o_readdata, e);
      i_read <= 0; i_write <= 0; i_second_pulse <= 0;
   endtask
   task pls(input f, input s, input int n);
      @(posedge I_CLOCK);
      i_first_pulse <= f; i_second_pulse <= s;
      repeat (n) @(posedge I_CLOCK);
      i_first_pulse <= 0; i_second_pulse <= 0;
   endtask
   task rst;
      I_RST <= 1;
      repeat (2) @(posedge I_CLOCK);
      I_RST <= 0;
   endtask
   initial begin
      #(90000 * 8);
      bad_count++;
      results;
   end
   initial begin
      rst;
      foreach (ra[i]) bus(ra[i], 0, 0, 0, 0);
      pls(1, 0, 300);
      bus(10'h04C, 0, 0, 0, 32'h01);
      bus(10'h050, 0, 0, 0, 32'h2C);
      pls(1, 0, 5);
      bus(10'h050, 0, 0, 0, 32'h2C);
      bus(10'h04C, 0, 0, 0, 32'h01);
      bus(10'h050, 0, 0, 0, 32'h31);
      i_sleep_mode <= 1;
      pls(0, 1, 3);
      i_sleep_mode <= 0;
      pls(0, 1, 2);
      bus(10'h05C, 0, 0, 0, 32'h00);
      bus(10'h060, 0, 0, 0, 32'h03);
      bus(10'h054, 0, 0, 1, 32'h00);
      bus(10'h054, 0, 0, 0, 32'h00);
      bus(10'h058, 0, 0, 0, 32'h02);
      i_sleep_mode <= 1;
      pls(0, 1, 65533);
      bus(10'h05C, 0, 0, 0, 32'h00);
      bus(10'h060, 0, 0, 0, 32'h00);
      bus(10'h080, 1, 32'h1, 0, 0);
      bus(10'h080, 0, 0, 0, 32'h1);
      bus(10'h04C, 1, 32'hFF, 0, 0);
      pls(1, 0, 8);
      bus(10'h04C, 0, 0, 0, 32'h01);
      bus(10'h050, 0, 0, 0, 32'h33);
      rst;
      bus(10'h04C, 0, 0, 0, 32'h00);
      bus(10'h080, 0, 0, 0, 32'h00);
      bus(10'h080, 1, 32'h2, 0, 0);
      pls(1, 0, 32);
      bus(10'h080, 1, 32'h3, 0, 0);
      pls(1, 0, 128);
      bus(10'h04C, 0, 0, 0, 32'h00);
      bus(10'h050, 0, 0, 0, 32'h04);
      results;
   end
endmodule
